// File: logic/smar_pkg.sv
package smar_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_COUNT = 13;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam int IDX_HSYNC = 0;
  localparam int IDX_VSYNC = 1;
  localparam int IDX_ACTIVE_PIXEL_COUNT = 2;
  localparam int IDX_VRES = 3;
  localparam int IDX_HSTART = 4;
  localparam int IDX_VSTART = 5;
  localparam int IDX_ATTR_A = 6;
  localparam int IDX_ATTR_B = 7;
  localparam int IDX_RATIO_M = 8;
  localparam int IDX_TU_SIZE = 9;
  localparam int IDX_RATIO_N = 10;
  localparam int IDX_PIX_CNT = 11;
  localparam int IDX_LANE_WC = 12;

  // ---------------------------------------------------------------
  // Byte offsets, writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_OFFSET [REG_COUNT] = '{
    12'h55c, 12'h560, 12'h564, 12'h568, 12'h56c, 12'h570, 12'h574,
    12'h578, 12'h57c, 12'h580, 12'h584, 12'h588, 12'h58c};
  localparam logic [DATA_W-1:0] REG_MASK [REG_COUNT] = '{
    32'h0000_7fff, 32'h0000_7fff, 32'h0000_ffff, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_0087,
    32'h00ff_ffff, 32'h0000_007e, 32'h00ff_ffff, 32'h0000_0007,
    32'h0000_ffff};
  localparam logic [DATA_W-1:0] REG_RESET [REG_COUNT] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0000_0040, 32'h0, 32'h0, 32'h0};
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h5fc;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SYNC_W = 15;
  localparam int RES_W = 16;
  localparam int RATIO_W = 24;
  localparam int TU_W = 7;
  localparam int PIX_W = 3;
  localparam int LANE_WC_W = 16;
  localparam int ATTR_SYNC_CLK = 0;
  localparam int ATTR_FMT_LO = 1;
  localparam int ATTR_FMT_HI = 2;
  localparam int ATTR_RANGE = 3;
  localparam int ATTR_COLORIM = 4;
  localparam int ATTR_DEPTH_LO = 5;
  localparam int ATTR_DEPTH_HI = 7;
  localparam int ATTRB_EVEN = 0;
  localparam int ATTRB_STEREO_LO = 1;
  localparam int ATTRB_STEREO_HI = 2;

  // ---------------------------------------------------------------
  // Field encodings and limits
  // ---------------------------------------------------------------
  localparam logic [PIX_W-1:0] PIX_SINGLE = 3'h1;
  localparam logic [PIX_W-1:0] PIX_DUAL = 3'h2;
  localparam logic [PIX_W-1:0] PIX_QUAD = 3'h4;
  localparam logic [TU_W-1:0] TU_MIN = 7'h20;
  localparam logic [TU_W-1:0] TU_MAX = 7'h40;
  localparam int ST_TU_OK = 0;
  localparam int ST_PIX_OK = 1;
  localparam int ST_AUTO_RATIO = 2;
  localparam int ST_MST_OK = 3;

endpackage

// File: logic/smar_field_reg.sv
`timescale 1ns/10ps
module smar_field_reg #(
  parameter logic [31:0] MASK = 32'hffff_ffff,
  parameter logic [31:0] RESET_VAL = 32'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Write side
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  // Stored value
  output logic [31:0] value
);

  // ---------------------------------------------------------------
  // Masked storage
  // ---------------------------------------------------------------
  // Unmasked bits hold their reset value, zero for every unused bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      value <= RESET_VAL & MASK;
    end else if (wrEn) begin
      value <= (wrData & MASK) | (value & ~MASK);
    end
  end

endmodule

// File: logic/smar_regs.sv
`timescale 1ns/10ps
// Behaviour
// - Hsync width is 15 bits, clocks
// - Vsync width is 15 bits, lines
// - Active pixels per line, 16 bits
// - Active lines per frame, 16 bits
// - Horizontal start offset, 16 bits
// - Vertical start offset, 16 bits
// - Attribute byte A fields as listed
// - Attribute byte B fields, 6:3 reserved
// - Async mode: device M, register untouched
// - Async N never copied into register
// - Transfer unit size resets to 64
// - Size bit 0 ignores writes
// - Pixel width selects 1, 2, 4
module smar_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [smar_pkg::ADDR_W-1:0] addr,
  input wire logic [smar_pkg::DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [smar_pkg::DATA_W-1:0] rdData,
  // Link mode and automatic ratio values
  input wire logic multiStreamTransportMode,
  input wire logic [smar_pkg::RATIO_W-1:0] autoRatioM,
  input wire logic [smar_pkg::RATIO_W-1:0] autoRatioN,
  // Timing to the framing logic
  output logic [smar_pkg::SYNC_W-1:0] hsyncPulseWidth,
  output logic [smar_pkg::SYNC_W-1:0] vsyncPulseWidth,
  output logic [smar_pkg::RES_W-1:0] activePixelsPerLine,
  output logic [smar_pkg::RES_W-1:0] activeLinesPerFrame,
  output logic [smar_pkg::RES_W-1:0] horizontalStartOffset,
  output logic [smar_pkg::RES_W-1:0] verticalStartOffset,
  // Attribute bytes
  output logic [7:0] streamAttrByteA,
  output logic [7:0] streamAttrByteB,
  output logic syncClockMode,
  output logic [1:0] componentFormat,
  output logic dynamicRange,
  output logic colorimetry,
  output logic [2:0] bitDepth,
  output logic interlaceEvenTotal,
  output logic [1:0] stereoAttr,
  // Ratio values inserted into the stream
  output logic [smar_pkg::RATIO_W-1:0] streamRatioM,
  output logic [smar_pkg::RATIO_W-1:0] streamRatioN,
  // Framing and input port setup
  output logic [smar_pkg::TU_W-1:0] framingUnitSize,
  output logic [2:0] pixelsPerClockOneHot,
  output logic [smar_pkg::LANE_WC_W-1:0] laneWordCount
);
  import smar_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [REG_COUNT-1:0] hit;
  logic [DATA_W-1:0] regValue [REG_COUNT];
  logic statusHit;

  assign statusHit = (addr == STATUS_OFFSET);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Masks keep only documented bits; bit 0 of the size never writes
  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : gen_reg
      assign hit[i] = (addr == REG_OFFSET[i]);
      smar_field_reg #(
        .MASK(REG_MASK[i]),
        .RESET_VAL(REG_RESET[i])
      ) u_field (
        .clock(clock),
        .nrst(nrst),
        .wrEn(wrEn && hit[i]),
        .wrData(wrData),
        .value(regValue[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Named views of stored fields
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] hsyncVal;
  logic [SYNC_W-1:0] vsyncVal;
  logic [RES_W-1:0] hresVal;
  logic [RES_W-1:0] vresVal;
  logic [RES_W-1:0] hstartVal;
  logic [RES_W-1:0] vstartVal;
  logic [7:0] attrAVal;
  logic [7:0] attrBVal;
  logic [RATIO_W-1:0] ratioMVal;
  logic [RATIO_W-1:0] ratioNVal;
  logic [TU_W-1:0] tuVal;
  logic [PIX_W-1:0] pixVal;
  logic [LANE_WC_W-1:0] laneWcVal;

  assign hsyncVal = regValue[IDX_HSYNC][SYNC_W-1:0];
  assign vsyncVal = regValue[IDX_VSYNC][SYNC_W-1:0];
  assign hresVal = regValue[IDX_ACTIVE_PIXEL_COUNT][RES_W-1:0];
  assign vresVal = regValue[IDX_VRES][RES_W-1:0];
  assign hstartVal = regValue[IDX_HSTART][RES_W-1:0];
  assign vstartVal = regValue[IDX_VSTART][RES_W-1:0];
  assign attrAVal = regValue[IDX_ATTR_A][7:0];
  assign attrBVal = regValue[IDX_ATTR_B][7:0];
  assign ratioMVal = regValue[IDX_RATIO_M][RATIO_W-1:0];
  assign ratioNVal = regValue[IDX_RATIO_N][RATIO_W-1:0];
  assign tuVal = regValue[IDX_TU_SIZE][TU_W-1:0];
  assign pixVal = regValue[IDX_PIX_CNT][PIX_W-1:0];
  assign laneWcVal = regValue[IDX_LANE_WC][LANE_WC_W-1:0];

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic tuInRange;
  logic pixLegal;
  logic mstWidthOk;
  logic [DATA_W-1:0] statusWord;

  assign tuInRange = (tuVal >= TU_MIN) && (tuVal <= TU_MAX);
  assign pixLegal = (pixVal == PIX_SINGLE) || (pixVal == PIX_DUAL) ||
    (pixVal == PIX_QUAD);
  assign mstWidthOk = !multiStreamTransportMode || (pixVal == PIX_QUAD);

  always_comb begin
    statusWord = '0;
    statusWord[ST_TU_OK] = tuInRange;
    statusWord[ST_PIX_OK] = pixLegal;
    statusWord[ST_AUTO_RATIO] = !attrAVal[ATTR_SYNC_CLK];
    statusWord[ST_MST_OK] = mstWidthOk;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Ratio registers return only what software wrote, never auto values
  logic [DATA_W-1:0] readMux;

  always_comb begin
    readMux = '0;
    for (int j = 0; j < REG_COUNT; j++) begin
      if (hit[j]) begin
        readMux = regValue[j];
      end
    end
    if (statusHit) begin
      readMux = statusWord;
    end
  end

  // Data stand for exactly one cycle after the read strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= readMux;
    end else begin
      rdData <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Timing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hsyncPulseWidth <= '0;
      vsyncPulseWidth <= '0;
      activePixelsPerLine <= '0;
      activeLinesPerFrame <= '0;
      horizontalStartOffset <= '0;
      verticalStartOffset <= '0;
    end else begin
      hsyncPulseWidth <= hsyncVal;
      vsyncPulseWidth <= vsyncVal;
      activePixelsPerLine <= hresVal;
      activeLinesPerFrame <= vresVal;
      horizontalStartOffset <= hstartVal;
      verticalStartOffset <= vstartVal;
    end
  end

  // ---------------------------------------------------------------
  // Attribute outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      streamAttrByteA <= '0;
      streamAttrByteB <= '0;
      syncClockMode <= 1'b0;
      componentFormat <= '0;
      dynamicRange <= 1'b0;
      colorimetry <= 1'b0;
      bitDepth <= '0;
      interlaceEvenTotal <= 1'b0;
      stereoAttr <= '0;
    end else begin
      streamAttrByteA <= attrAVal;
      streamAttrByteB <= attrBVal;
      syncClockMode <= attrAVal[ATTR_SYNC_CLK];
      componentFormat <= attrAVal[ATTR_FMT_HI:ATTR_FMT_LO];
      dynamicRange <= attrAVal[ATTR_RANGE];
      colorimetry <= attrAVal[ATTR_COLORIM];
      bitDepth <= attrAVal[ATTR_DEPTH_HI:ATTR_DEPTH_LO];
      interlaceEvenTotal <= attrBVal[ATTRB_EVEN];
      stereoAttr <= attrBVal[ATTRB_STEREO_HI:ATTRB_STEREO_LO];
    end
  end

  // ---------------------------------------------------------------
  // Ratio values sent in the stream
  // ---------------------------------------------------------------
  // Synchronous mode sends the programmed pair; otherwise the
  // automatically computed pair goes out and the registers stay put
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      streamRatioM <= '0;
      streamRatioN <= '0;
    end else if (attrAVal[ATTR_SYNC_CLK]) begin
      streamRatioM <= ratioMVal;
      streamRatioN <= ratioNVal;
    end else begin
      streamRatioM <= autoRatioM;
      streamRatioN <= autoRatioN;
    end
  end

  // ---------------------------------------------------------------
  // Framing and input port outputs
  // ---------------------------------------------------------------
  // Unknown width codes leave the port in single pixel mode
  logic [2:0] pixOneHotNext;

  always_comb begin
    case (pixVal)
      PIX_DUAL: pixOneHotNext = 3'h2;
      PIX_QUAD: pixOneHotNext = 3'h4;
      default: pixOneHotNext = 3'h1;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      framingUnitSize <= REG_RESET[IDX_TU_SIZE][TU_W-1:0];
      pixelsPerClockOneHot <= 3'h1;
      laneWordCount <= '0;
    end else begin
      framingUnitSize <= tuVal;
      pixelsPerClockOneHot <= pixOneHotNext;
      laneWordCount <= laneWcVal;
    end
  end

endmodule

// File: sim/smar_regs_chk.sv
`timescale 1ns/10ps
module smar_regs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [smar_pkg::ADDR_W-1:0] addr,
  input wire logic [smar_pkg::DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [smar_pkg::DATA_W-1:0] rdData,
  // Watched outputs and the automatic M ratio input
  input wire logic [smar_pkg::RATIO_W-1:0] autoRatioM,
  input wire logic [smar_pkg::RATIO_W-1:0] streamRatioM,
  input wire logic [smar_pkg::SYNC_W-1:0] hsyncPulseWidth,
  input wire logic [smar_pkg::RES_W-1:0] activePixelsPerLine,
  input wire logic [7:0] streamAttrByteA,
  input wire logic [7:0] streamAttrByteB,
  input wire logic syncClockMode,
  input wire logic [1:0] componentFormat,
  input wire logic [2:0] bitDepth,
  input wire logic [smar_pkg::TU_W-1:0] framingUnitSize,
  input wire logic [2:0] pixelsPerClockOneHot
);
  import smar_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_hsync_follow: assert property (
    wrEn && addr == 12'h55c |-> ##2
    hsyncPulseWidth == $past(wrData[14:0], 2)) else $error("hsync width");
  a_active_pixel_count_follow: assert property (
    wrEn && addr == 12'h564 |-> ##2
    activePixelsPerLine == $past(wrData[15:0], 2)) else $error("active_pixel_count");
  a_attr_fields: assert property (
    bitDepth == streamAttrByteA[7:5] && componentFormat ==
    streamAttrByteA[2:1] && syncClockMode == streamAttrByteA[0])
    else $error("attr A fields");
  a_attr_resv: assert property (
    streamAttrByteB[6:3] == 4'h0) else $error("attr B reserved");
  a_ratio_auto: assert property (
    !syncClockMode && !$past(syncClockMode) && $past(nrst) |->
    streamRatioM == $past(autoRatioM)) else $error("auto ratio");
  a_tu_reset: assert property (
    $rose(nrst) |-> framingUnitSize == 7'h40 &&
    pixelsPerClockOneHot == 3'h1) else $error("reset values");
  a_tu_even: assert property (
    wrEn && addr == 12'h580 |-> ##2
    framingUnitSize == {$past(wrData[6:1], 2), 1'b0}) else $error("tu");
  a_pix_select: assert property (
    wrEn && addr == 12'h588 |-> ##2 pixelsPerClockOneHot ==
    (($past(wrData[2:0], 2) == 3'h2) ? 3'h2 :
    ($past(wrData[2:0], 2) == 3'h4) ? 3'h4 : 3'h1)) else $error("pix");
  a_resv_read: assert property (
    rdEn && addr == 12'h588 |=> rdData[31:3] == 29'h0)
    else $error("reserved read");

  c_tu_write: cover property (wrEn && addr == 12'h580);
  c_rd_data: cover property (rdData != 32'h0);
  c_auto: cover property (!syncClockMode && streamRatioM != 24'h0);
endmodule

bind smar_regs smar_regs_chk u_chk (.clock(clock), .nrst(nrst),
  .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .autoRatioM(autoRatioM), .streamRatioM(streamRatioM),
  .hsyncPulseWidth(hsyncPulseWidth),
  .activePixelsPerLine(activePixelsPerLine),
  .streamAttrByteA(streamAttrByteA), .streamAttrByteB(streamAttrByteB),
  .syncClockMode(syncClockMode), .componentFormat(componentFormat),
  .bitDepth(bitDepth), .framingUnitSize(framingUnitSize),
  .pixelsPerClockOneHot(pixelsPerClockOneHot));

// File: sim/smar_regs_tb_top.sv
`timescale 1ns/10ps
module smar_regs_tb_top;
  import smar_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic mstMode = 1'b0;
  logic [ADDR_W-1:0] addr = 12'h0;
  logic [DATA_W-1:0] wrData = 32'h0;
  logic [DATA_W-1:0] rdData, got, d;
  logic [RATIO_W-1:0] autoM = 24'h0;
  logic [RATIO_W-1:0] autoN = 24'h0;
  logic [RATIO_W-1:0] ratioM, ratioN;
  logic [SYNC_W-1:0] hsw, vsw;
  logic [RES_W-1:0] active_pixel_count, vres, hst, vst;
  logic [7:0] attrA, attrB;
  logic syncClk, dynRange, colorim, evenTot;
  logic [1:0] compFmt, stereo;
  logic [2:0] depth, pixHot;
  logic [TU_W-1:0] tuSize;
  logic [LANE_WC_W-1:0] laneWc;
  int badCount = 0;
  int numChecks = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  smar_regs dut (.clock(clock), .nrst(nrst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .multiStreamTransportMode(mstMode), .autoRatioM(autoM),
    .autoRatioN(autoN), .hsyncPulseWidth(hsw), .vsyncPulseWidth(vsw),
    .activePixelsPerLine(active_pixel_count), .activeLinesPerFrame(vres),
    .horizontalStartOffset(hst), .verticalStartOffset(vst),
    .streamAttrByteA(attrA), .streamAttrByteB(attrB),
    .syncClockMode(syncClk), .componentFormat(compFmt),
    .dynamicRange(dynRange), .colorimetry(colorim), .bitDepth(depth),
    .interlaceEvenTotal(evenTot), .stereoAttr(stereo),
    .streamRatioM(ratioM), .streamRatioN(ratioN),
    .framingUnitSize(tuSize), .pixelsPerClockOneHot(pixHot),
    .laneWordCount(laneWc));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= v;
    @(posedge clock);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clock);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clock);
    rdEn <= 1'b0;
    @(negedge clock);
    v = rdData;
    @(posedge clock);
  endtask

  // Field output for a register index, all ones when not mirrored
  function automatic logic [31:0] field(int k);
    case (k)
      IDX_HSYNC: return {17'h0, hsw};
      IDX_VSYNC: return {17'h0, vsw};
      IDX_ACTIVE_PIXEL_COUNT: return {16'h0, active_pixel_count};
      IDX_VRES: return {16'h0, vres};
      IDX_HSTART: return {16'h0, hst};
      IDX_VSTART: return {16'h0, vst};
      IDX_ATTR_A: return {24'h0, attrA};
      IDX_ATTR_B: return {24'h0, attrB};
      IDX_TU_SIZE: return {25'h0, tuSize};
      IDX_LANE_WC: return {16'h0, laneWc};
      default: return 32'hffff_ffff;
    endcase
  endfunction

  function automatic logic [2:0] pix_exp(logic [2:0] c);
    return (c == 3'h2) ? 3'h2 : (c == 3'h4) ? 3'h4 : 3'h1;
  endfunction

  // Per-lane word count that software programs for a line
  function automatic logic [31:0] lane_count(int pix, int bpp, int lanes);
    int words;
    words = (pix * bpp + 15) / 16;
    if (lanes == 1) begin
      return 32'(words - 1);
    end
    if (words % lanes == 0) begin
      return 32'(words - lanes);
    end
    return 32'(words + words % lanes - lanes);
  endfunction

  task automatic testDone;
    if (badCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      testDone();
    end
  end

  initial begin
    void'($urandom(32'hb0697c5d));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    for (int i = 0; i < REG_COUNT; i++) begin
      rd(REG_OFFSET[i], got);
      chk(got, REG_RESET[i]);
    end
    chk({29'h0, pixHot}, 32'h1);
    // ---------------------------------------------------------------
    // Write and readback, all ones first, then random
    // ---------------------------------------------------------------
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        d = (p == 0) ? 32'hffff_ffff : $urandom;
        mstMode <= 1'($urandom);
        autoM <= 24'($urandom);
        wr(REG_OFFSET[i], d);
        rd(REG_OFFSET[i], got);
        chk(got, d & REG_MASK[i]);
        if (field(i) !== 32'hffff_ffff) begin
          chk(field(i), d & REG_MASK[i]);
        end
        if (i == IDX_ATTR_A) begin
          chk({24'h0, depth, colorim, dynRange, compFmt, syncClk},
            {24'h0, d[7:0]});
        end
        if (i == IDX_ATTR_B) begin
          chk({29'h0, stereo, evenTot}, {29'h0, d[2:0]});
        end
      end
    end
    // ---------------------------------------------------------------
    // Transfer unit size edges and pixel width codes
    // ---------------------------------------------------------------
    foreach (REG_RESET[j]) begin
      d = 32'(32 + $urandom % 33);
      if (j < 2) begin
        d = (j == 0) ? 32'h21 : 32'h41;
      end
      wr(12'h580, d);
      rd(12'h580, got);
      chk(got, {25'h0, d[6:1], 1'b0});
    end
    for (int c = 0; c < 8; c++) begin
      wr(12'h588, c);
      rd(12'h588, got);
      chk({29'h0, pixHot}, {29'h0, pix_exp(3'(c))});
    end
    // ---------------------------------------------------------------
    // Ratio values, automatic then programmed
    // ---------------------------------------------------------------
    wr(12'h57c, 32'h12_3456);
    wr(12'h584, 32'h65_4321);
    wr(12'h574, 32'h0);
    autoM <= 24'($urandom);
    autoN <= 24'($urandom);
    rd(12'h57c, got);
    chk(got, 32'h12_3456);
    chk({8'h0, ratioM}, {8'h0, autoM});
    chk({8'h0, ratioN}, {8'h0, autoN});
    rd(12'h584, got);
    chk(got, 32'h65_4321);
    wr(12'h574, 32'h1);
    rd(12'h574, got);
    chk({8'h0, ratioM}, 32'h12_3456);
    chk({8'h0, ratioN}, 32'h65_4321);
    // Status word, quad width needed in multi-stream mode
    mstMode <= 1'b1;
    wr(12'h588, 32'h4);
    rd(STATUS_OFFSET, got);
    chk(got, 32'hb);
    wr(12'h588, 32'h2);
    rd(STATUS_OFFSET, got);
    chk(got, 32'h3);
    // Lane word counts for one, two and four lanes
    for (int n = 0; n < 3; n++) begin
      d = lane_count(64 + $urandom % 4000, 8 * (2 + $urandom % 5), 1 << n);
      wr(12'h58c, d);
      rd(12'h58c, got);
      chk(got, d);
      chk({16'h0, laneWc}, d);
    end
    // Unmapped place
    wr(12'h590, $urandom);
    rd(12'h590, got);
    chk(got, 32'h0);
    // ---------------------------------------------------------------
    // Reset in mid-run
    // ---------------------------------------------------------------
    @(posedge clock);
    nrst <= 1'b0;
    @(negedge clock);
    chk({25'h0, tuSize}, 32'h40);
    @(posedge clock);
    nrst <= 1'b1;
    rd(12'h580, got);
    chk(got, 32'h40);
    testDone();
  end
endmodule
